// [rtl/slp_defs.vh]
// Constants for the sleep controller and indirect queue
`ifndef SLP_DEFS_VH
`define SLP_DEFS_VH
`define SLP_CLK_HZ          20000000
`define SLP_MODE_NORMAL     4'h0
`define SLP_MODE_PIN        4'h1
`define SLP_MODE_CYCLIC     4'h4
`define SLP_MODE_CYC_PIN    4'h5
`define SLP_MODE_SUPPORT    4'h7
`define SLP_MODE_SYNC_CYC   4'h8
`define SLP_ROLE_NONE       2'h0
`define SLP_ROLE_COORD      2'h1
`define SLP_ROLE_POLLER     2'h2
`define SLP_PURGE_NUM       5
`define SLP_PURGE_DEN       2
`define SLP_PURGE_STATUS    8'h75
`define SLP_POLL_MS_HI      100
`define SLP_POLL_MS_LO      300
`define SLP_MS_CYCLES       20000
`define SLP_ADDR_CTRL       8'h00
`define SLP_ADDR_SLEEP_PER  8'h04
`define SLP_ADDR_WAKE_HOLD  8'h08
`define SLP_ADDR_DEST_HI    8'h0c
`define SLP_ADDR_DEST_LO    8'h10
`define SLP_ADDR_STATUS     8'h14
`define SLP_ADDR_SYNC_SLEEP 8'h18
`define SLP_ADDR_SYNC_WAKE  8'h1c
`define SLP_ADDR_PURGE      8'h20
`define SLP_CTRL_MODE_LSB   0
`define SLP_CTRL_ROLE_LSB   4
`define SLP_CTRL_FLOW_BIT   6
`define SLP_CTRL_IND_BIT    7
`define SLP_CTRL_API_BIT    8
`define SLP_CTRL_RATE_BIT   9
`define SLP_SLEEP_PER_RST   32'h00000064
`define SLP_WAKE_HOLD_RST   32'h0000000a
`endif

// [rtl/slp_ctrl.v]
// Sleep-state controller with indirect message queue and poller
// Operation
// - Reset selects normal mode, never sleeps
// - Normal mode relays sync, never originates
// - Mode 1: pin high sleeps, low wakes
// - Async modes poll parent on each wake
// - Mode 4: sleep period, brief wake, extend
// - Awake indicator high awake, low asleep
// - Flow control: CTS low awake, high asleep
// - Mode 5: pin cycles, released pin wakes
// - Mode 7: never sleeps, sends when network awake
// - Support node answers joiners with sync
// - Mode 8: wakes with network, deaf asleep
// - Mode 8: network times replace local after sync
// - Mode 8 indicator and CTS follow wake
// - Unsynced sleeper polls for sync, sleeps
// - Modes 4, 5: data starts and restarts wake hold timer
// - Coordinator queues unicasts, one per poll
// - Purge after 2.5 sleep periods, status 75
// - Full queue stalls serial, frees on poll
// - Broadcasts and mesh bypass the queue
// - Poller polls destination; unicast counts
// - Async sleeper polls soon after each wake
// - Poll interval 100ms or 300ms awake
`timescale 1ns/10ps
`include "slp_defs.vh"
module slp_ctrl #(
  parameter DEPTH     = 4,
  parameter IDX_W     = 2,
  parameter MS_CYCLES = `SLP_MS_CYCLES
) (
  input  wire        clk_sys,
  input  wire        reset_n,
  input  wire [7:0]  wb_adr_i,
  input  wire [31:0] wb_dat_i,
  output reg  [31:0] wb_dat_o,
  input  wire [3:0]  wb_sel_i,
  input  wire        wb_we_i,
  input  wire        wb_cyc_i,
  input  wire        wb_stb_i,
  output reg         wb_ack_o,
  input  wire        sleep_request_pin,
  input  wire        serial_data_rx,
  input  wire        rf_data_rx,
  input  wire        ser_tx_valid,
  input  wire        ser_tx_unicast,
  input  wire [63:0] ser_tx_dest,
  input  wire        ser_fifo_full,
  output reg         ser_tx_ready_q,
  input  wire        rf_poll_rx,
  input  wire [63:0] rf_poll_src,
  input  wire        rf_sync_rx,
  input  wire [31:0] rf_sync_sleep,
  input  wire [31:0] rf_sync_wake,
  input  wire        rf_join_req,
  input  wire        net_awake,
  input  wire        rf_busy,
  output reg         rf_send_q,
  output reg  [63:0] rf_send_dest_q,
  output reg  [IDX_W-1:0] rf_send_slot_q,
  output reg         rf_send_poll_q,
  output reg         rf_send_sync_q,
  output reg         rf_relay_sync_q,
  output reg         rf_rx_enable_q,
  output reg         tx_status_q,
  output reg  [7:0]  tx_status_code_q,
  output reg         awake_q,
  output reg         cts_n_q
);
////////////////////////////////////////////////////////////////////////////////
  localparam ST_AWAKE = 3'b001;
  localparam ST_HOLD  = 3'b010;
  localparam ST_SLEEP = 3'b100;

  reg  [11:0] ctrl_q;
  reg  [31:0] sleep_period_q;
  reg  [31:0] wake_hold_time_q;
  reg  [31:0] dest_hi_q;
  reg  [31:0] dest_lo_q;
  reg  [31:0] net_sleep_q;
  reg  [31:0] net_wake_q;
  reg  [7:0]  purge_cnt_q;
  reg         synced_q;
  reg  [2:0]  state_q;
  reg  [31:0] tmr_q;
  reg  [14:0] ms_cnt_q;
  reg  [31:0] poll_tmr_q;
  reg         poll_due_q;
  reg  [DEPTH-1:0]  qv_q;
  reg  [63:0] qdest_q [0:DEPTH-1];
  reg  [31:0] qage_q  [0:DEPTH-1];

  wire [3:0]  sleep_mode_select      = ctrl_q[`SLP_CTRL_MODE_LSB +: 4];
  wire [1:0]  role                   = ctrl_q[`SLP_CTRL_ROLE_LSB +: 2];
  wire        flow_control_enable    = ctrl_q[`SLP_CTRL_FLOW_BIT];
  wire        awake_indicator_enable = ctrl_q[`SLP_CTRL_IND_BIT];
  wire        api_mode               = ctrl_q[`SLP_CTRL_API_BIT];
  wire        high_rate              = ctrl_q[`SLP_CTRL_RATE_BIT];
  wire [63:0] dest_addr              = {dest_hi_q, dest_lo_q};
  wire        ms_tick                = (ms_cnt_q == MS_CYCLES - 1);
  wire        m_pin  = (sleep_mode_select == `SLP_MODE_PIN);
  wire        m_cyc  = (sleep_mode_select == `SLP_MODE_CYCLIC);
  wire        m_cpin = (sleep_mode_select == `SLP_MODE_CYC_PIN);
  wire        m_sup  = (sleep_mode_select == `SLP_MODE_SUPPORT);
  wire        m_sync = (sleep_mode_select == `SLP_MODE_SYNC_CYC);
  wire        m_norm = !(m_pin | m_cyc | m_cpin | m_sup | m_sync);
  wire        async_mode = m_pin | m_cyc | m_cpin;
  wire        data_rx = serial_data_rx | rf_data_rx;
  // In mode 8, network times take over once a sync has been heard
  wire [31:0] eff_sleep = (m_sync && synced_q) ? net_sleep_q : sleep_period_q;
  wire [31:0] eff_wake  = (m_sync && synced_q) ? net_wake_q : wake_hold_time_q;
  wire        awake = (state_q != ST_SLEEP);
  wire [31:0] purge_lim = (sleep_period_q * `SLP_PURGE_NUM) / `SLP_PURGE_DEN;
  wire [31:0] poll_lim = high_rate ? `SLP_POLL_MS_HI : `SLP_POLL_MS_LO;
  wire        wb_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  // One poll per due flag: the pulse itself blocks a repeat in the next cycle
  wire        poll_fire = poll_due_q && !rf_send_poll_q && role == `SLP_ROLE_POLLER && awake;

  reg [IDX_W-1:0] free_idx;
  reg             free_ok;
  reg [IDX_W-1:0] hit_idx;
  reg             hit_ok;
  integer         i;
  always @* begin
    free_idx = {IDX_W{1'b0}};
    free_ok  = 1'b0;
    hit_idx  = {IDX_W{1'b0}};
    hit_ok   = 1'b0;
    for (i = DEPTH - 1; i >= 0; i = i - 1) begin
      if (!qv_q[i]) begin
        free_idx = i[IDX_W-1:0];
        free_ok  = 1'b1;
      end
      if (qv_q[i] && qdest_q[i] == rf_poll_src) begin
        hit_idx = i[IDX_W-1:0];
        hit_ok  = 1'b1;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // Register bus: ack registered one cycle after the request, single-cycle pulse
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      wb_ack_o         <= 1'b0;
      wb_dat_o         <= 32'h00000000;
      ctrl_q           <= 12'h000;
      sleep_period_q   <= `SLP_SLEEP_PER_RST;
      wake_hold_time_q <= `SLP_WAKE_HOLD_RST;
      dest_hi_q        <= 32'h00000000;
      dest_lo_q        <= 32'h00000000;
    end else begin
      wb_ack_o <= wb_req;
      if (wb_req && wb_we_i) begin
        case (wb_adr_i)
          `SLP_ADDR_CTRL: begin
            if (wb_sel_i[0])
              ctrl_q[7:0] <= wb_dat_i[7:0];
            if (wb_sel_i[1])
              ctrl_q[11:8] <= wb_dat_i[11:8];
          end
          `SLP_ADDR_SLEEP_PER: sleep_period_q <= wb_dat_i;
          `SLP_ADDR_WAKE_HOLD: wake_hold_time_q <= wb_dat_i;
          `SLP_ADDR_DEST_HI:   dest_hi_q <= wb_dat_i;
          `SLP_ADDR_DEST_LO:   dest_lo_q <= wb_dat_i;
          default: ;
        endcase
      end
      if (wb_req && !wb_we_i) begin
        case (wb_adr_i)
          `SLP_ADDR_CTRL:       wb_dat_o <= {20'h00000, ctrl_q};
          `SLP_ADDR_SLEEP_PER:  wb_dat_o <= sleep_period_q;
          `SLP_ADDR_WAKE_HOLD:  wb_dat_o <= wake_hold_time_q;
          `SLP_ADDR_DEST_HI:    wb_dat_o <= dest_hi_q;
          `SLP_ADDR_DEST_LO:    wb_dat_o <= dest_lo_q;
          `SLP_ADDR_STATUS:     wb_dat_o <= {16'h0000, {(8-DEPTH){1'b0}}, qv_q,
                                             4'h0, synced_q, state_q};
          `SLP_ADDR_SYNC_SLEEP: wb_dat_o <= net_sleep_q;
          `SLP_ADDR_SYNC_WAKE:  wb_dat_o <= net_wake_q;
          `SLP_ADDR_PURGE:      wb_dat_o <= {24'h000000, purge_cnt_q};
          default:              wb_dat_o <= 32'h00000000;
        endcase
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // Sleep state machine, timer counts milliseconds
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ms_cnt_q    <= 15'h0000;
      state_q     <= ST_AWAKE;
      tmr_q       <= 32'h00000000;
      synced_q    <= 1'b0;
      net_sleep_q <= 32'h00000000;
      net_wake_q  <= 32'h00000000;
    end else begin
      ms_cnt_q <= ms_tick ? 15'h0000 : ms_cnt_q + 15'h0001;
      if (rf_sync_rx && (m_sync || m_sup || m_norm)) begin
        synced_q    <= 1'b1;
        net_sleep_q <= rf_sync_sleep;
        net_wake_q  <= rf_sync_wake;
      end
      case (state_q)
        // Awake: decide at once whether to hold or sleep
        ST_AWAKE: begin
          if (m_pin && sleep_request_pin && !rf_busy)
            state_q <= ST_SLEEP;
          else if ((m_cyc || (m_cpin && sleep_request_pin)) && !rf_busy) begin
            if (data_rx) begin
              state_q <= ST_HOLD;
              tmr_q   <= eff_wake;
            end else begin
              state_q <= ST_SLEEP;
              tmr_q   <= eff_sleep;
            end
          end else if (m_sync) begin
            state_q <= ST_HOLD;
            tmr_q   <= eff_wake;
          end
        end
        // Hold: wake time counts down, data (modes 4, 5) or a network sync (mode 8) restarts it
        ST_HOLD: begin
          if (m_norm || m_sup || (m_cpin && !sleep_request_pin) || m_pin)
            state_q <= ST_AWAKE;
          else if (m_sync && rf_sync_rx)
            tmr_q <= rf_sync_wake;
          else if (data_rx && !m_sync)
            tmr_q <= eff_wake;
          else if (ms_tick) begin
            if (tmr_q == 32'h00000000 && !rf_busy) begin
              state_q <= ST_SLEEP;
              tmr_q   <= eff_sleep;
            end else if (tmr_q != 32'h00000000)
              tmr_q <= tmr_q - 32'h00000001;
          end
        end
        // Asleep: pin release, a first sync or the timer end wakes
        ST_SLEEP: begin
          if (m_norm || m_sup)
            state_q <= ST_AWAKE;
          else if (m_pin && !sleep_request_pin)
            state_q <= ST_AWAKE;
          else if (m_cpin && !sleep_request_pin)
            state_q <= ST_AWAKE;
          else if (m_sync && rf_sync_rx && !synced_q)
            state_q <= ST_AWAKE;
          else if (ms_tick && !m_pin) begin
            if (tmr_q == 32'h00000000)
              state_q <= ST_AWAKE;
            else
              tmr_q <= tmr_q - 32'h00000001;
          end
        end
        default: state_q <= ST_AWAKE;
      endcase
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // Indirect queue, poll scheduler and RF requests
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      qv_q             <= {DEPTH{1'b0}};
      rf_send_q        <= 1'b0;
      rf_send_dest_q   <= 64'h0000000000000000;
      rf_send_slot_q   <= {IDX_W{1'b0}};
      rf_send_poll_q   <= 1'b0;
      rf_send_sync_q   <= 1'b0;
      rf_relay_sync_q  <= 1'b0;
      tx_status_q      <= 1'b0;
      tx_status_code_q <= 8'h00;
      purge_cnt_q      <= 8'h00;
      poll_tmr_q       <= 32'h00000000;
      poll_due_q       <= 1'b0;
      ser_tx_ready_q   <= 1'b0;
    end else begin
      rf_send_q       <= 1'b0;
      rf_send_poll_q  <= 1'b0;
      rf_send_sync_q  <= 1'b0;
      rf_relay_sync_q <= 1'b0;
      tx_status_q     <= 1'b0;
      // Serial accepted only while awake; a full coordinator queue stalls
      // the whole serial stream so that nothing jumps ahead of a held unicast
      if (!awake)
        ser_tx_ready_q <= 1'b0;
      else if (role == `SLP_ROLE_COORD && !free_ok)
        ser_tx_ready_q <= 1'b0;
      else
        ser_tx_ready_q <= 1'b1;
      // Relay only: sync messages are never originated here in normal mode
      rf_relay_sync_q <= rf_sync_rx && synced_q && !m_sync;
      if (rf_join_req && m_sup)
        rf_send_sync_q <= 1'b1;
      else if (m_sync && !synced_q && awake && state_q == ST_AWAKE)
        rf_send_sync_q <= 1'b1;
      // Age queued slots in ms and drop stale ones
      for (i = 0; i < DEPTH; i = i + 1) begin
        if (qv_q[i] && ms_tick) begin
          if (qage_q[i] >= purge_lim) begin
            qv_q[i]          <= 1'b0;
            purge_cnt_q      <= purge_cnt_q + 8'h01;
            tx_status_q      <= api_mode;
            tx_status_code_q <= `SLP_PURGE_STATUS;
          end else
            qage_q[i] <= qage_q[i] + 32'h00000001;
        end
      end
      // Serial take, then poll answer, then own poll: one RF request a cycle
      if (ser_tx_valid && ser_tx_ready_q) begin
        if (role == `SLP_ROLE_COORD && ser_tx_unicast) begin
          if (free_ok) begin
            qv_q[free_idx]    <= 1'b1;
            qdest_q[free_idx] <= ser_tx_dest;
            qage_q[free_idx]  <= 32'h00000000;
          end
        end else if (!m_sup || net_awake) begin
          rf_send_q      <= 1'b1;
          rf_send_dest_q <= ser_tx_dest;
        end
      end else if (rf_poll_rx && role == `SLP_ROLE_COORD && hit_ok) begin
        qv_q[hit_idx]  <= 1'b0;
        rf_send_q      <= 1'b1;
        rf_send_slot_q <= hit_idx;
        rf_send_dest_q <= rf_poll_src;
      end else if (poll_fire) begin
        rf_send_poll_q <= 1'b1;
        rf_send_dest_q <= dest_addr;
      end
      // Poll timer: due after each wake in async modes and at the awake interval
      if (role != `SLP_ROLE_POLLER || !awake) begin
        poll_tmr_q <= 32'h00000000;
        poll_due_q <= async_mode;
      end else if (rf_send_poll_q
                   || (ser_tx_valid && ser_tx_ready_q && ser_tx_dest == dest_addr)) begin
        poll_tmr_q <= 32'h00000000;
        poll_due_q <= 1'b0;
      end else if (ms_tick) begin
        if (poll_tmr_q + 32'h00000001 >= poll_lim)
          poll_due_q <= 1'b1;
        else
          poll_tmr_q <= poll_tmr_q + 32'h00000001;
      end
    end
  end
////////////////////////////////////////////////////////////////////////////////
  // Sleep status pins
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      awake_q        <= 1'b1;
      cts_n_q        <= 1'b1;
      rf_rx_enable_q <= 1'b1;
    end else begin
      // Mode 8 shows the indicator only when enabled; other modes always do
      if (m_sync && !awake_indicator_enable)
        awake_q <= 1'b0;
      else
        awake_q <= awake;
      // Without flow control the pin stays asserted
      if (!flow_control_enable)
        cts_n_q <= 1'b0;
      else if (!awake)
        cts_n_q <= 1'b1;
      else if (ser_fifo_full && role == `SLP_ROLE_COORD)
        cts_n_q <= 1'b1;
      else
        cts_n_q <= 1'b0;
      rf_rx_enable_q <= awake;
    end
  end
endmodule

// [dv/slp_ctrl_assertions.sv]
// Port checker for the sleep controller, bound to its top module
`timescale 1ns/10ps
module slp_ctrl_chk (
  input wire        clk_sys,
  input wire        reset_n,
  input wire [7:0]  wb_adr_i,
  input wire [31:0] wb_dat_i,
  input wire [3:0]  wb_sel_i,
  input wire        wb_we_i,
  input wire        wb_cyc_i,
  input wire        wb_stb_i,
  input wire        wb_ack_o,
  input wire        sleep_request_pin,
  input wire        rf_busy,
  input wire        net_awake,
  input wire        ser_tx_valid,
  input wire        ser_tx_unicast,
  input wire [63:0] ser_tx_dest,
  input wire        ser_fifo_full,
  input wire        ser_tx_ready_q,
  input wire        rf_send_q,
  input wire [63:0] rf_send_dest_q,
  input wire        rf_rx_enable_q,
  input wire        tx_status_q,
  input wire [7:0]  tx_status_code_q,
  input wire        awake_q,
  input wire        cts_n_q
);
  // Shadow of the control register, updated on the edge the write is taken
  reg  [9:0] ctrl_q;
  wire [3:0] mode;
  assign mode = ctrl_q[3:0];
  always @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      ctrl_q <= 10'h000;
    end else if (wb_cyc_i && wb_stb_i && wb_we_i && !wb_ack_o && wb_adr_i == 8'h00) begin
      if (wb_sel_i[0]) ctrl_q[7:0] <= wb_dat_i[7:0];
      if (wb_sel_i[1]) ctrl_q[9:8] <= wb_dat_i[9:8];
    end
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  ////////////////////////////////////////////////////////////////////////////
  property p_ack_once;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  a_ack_once: assert property (p_ack_once) else $error("ack held past one cycle");
  property p_normal_awake;
    (mode == 4'h0)[*3] |-> awake_q && rf_rx_enable_q;
  endproperty
  a_normal_awake: assert property (p_normal_awake) else $error("normal mode slept");
  property p_ind_follows;
    mode != 4'h8 |-> awake_q == rf_rx_enable_q;
  endproperty
  a_ind_follows: assert property (p_ind_follows) else $error("indicator off state");
  property p_cts_sleep;
    (ctrl_q[6] && !rf_rx_enable_q)[*2] |-> cts_n_q;
  endproperty
  a_cts_sleep: assert property (p_cts_sleep) else $error("cts low while asleep");
  property p_sleep_refuse;
    (!rf_rx_enable_q)[*2] |-> !ser_tx_ready_q;
  endproperty
  a_sleep_refuse: assert property (p_sleep_refuse) else $error("serial taken asleep");
  property p_pin_sleep;
    (mode == 4'h1 && sleep_request_pin && !rf_busy)[*6] |-> !rf_rx_enable_q;
  endproperty
  a_pin_sleep: assert property (p_pin_sleep) else $error("pin sleep not entered");
  property p_pin_busy;
    mode == 4'h1 && rf_busy && rf_rx_enable_q |=> rf_rx_enable_q;
  endproperty
  a_pin_busy: assert property (p_pin_busy) else $error("slept during busy");
  property p_pin_wake;
    ((mode == 4'h1 || mode == 4'h5) && !sleep_request_pin)[*6] |-> rf_rx_enable_q;
  endproperty
  a_pin_wake: assert property (p_pin_wake) else $error("released pin left asleep");
  property p_bypass;
    ser_tx_valid && ser_tx_ready_q && !ser_tx_unicast && (mode != 4'h7 || net_awake) |=>
      rf_send_q && rf_send_dest_q == $past(ser_tx_dest);
  endproperty
  a_bypass: assert property (p_bypass) else $error("broadcast not sent at once");
  property p_queue;
    ctrl_q[5:4] == 2'h1 && ser_tx_valid && ser_tx_ready_q && ser_tx_unicast |=> !rf_send_q;
  endproperty
  a_queue: assert property (p_queue) else $error("unicast sent without poll");
  property p_purge_code;
    tx_status_q |-> tx_status_code_q == 8'h75 && ctrl_q[8];
  endproperty
  a_purge_code: assert property (p_purge_code) else $error("bad purge status");
  property p_fifo_cts;
    ctrl_q[6] && ser_fifo_full |-> ##[1:2] cts_n_q;
  endproperty
  a_fifo_cts: assert property (p_fifo_cts) else $error("cts low with full queue");
endmodule
bind slp_ctrl slp_ctrl_chk u_chk (.*);

// [dv/slp_host_model.sv]
// Host model driving the sleep request pin and serial transmit requests
`timescale 1ns/10ps
module slp_host_model (
  input  wire        clk_sys,
  input  wire        ser_tx_ready_q,
  output reg         sleep_request_pin,
  output reg         serial_data_rx,
  output reg         ser_tx_valid,
  output reg         ser_tx_unicast,
  output reg  [63:0] ser_tx_dest,
  output reg         ser_fifo_full
);
  initial begin
    sleep_request_pin = 1'b0;
    serial_data_rx    = 1'b0;
    ser_tx_valid      = 1'b0;
    ser_tx_unicast    = 1'b0;
    ser_tx_dest       = 64'h0;
    ser_fifo_full     = 1'b0;
  end
  // High asks for sleep, low for wake
  task set_pin(input logic lvl);
    @(posedge clk_sys);
    sleep_request_pin <= lvl;
  endtask
  task set_full(input logic lvl);
    @(posedge clk_sys);
    ser_fifo_full <= lvl;
  endtask
  task data_pulse;
    @(posedge clk_sys);
    serial_data_rx <= 1'b1;
    @(posedge clk_sys);
    serial_data_rx <= 1'b0;
  endtask
  // Held until ready or lim cycles pass; released fields show an inverted pattern
  task send(input logic uni, input logic [63:0] dst, input int lim, output logic ok);
    int n;
    @(posedge clk_sys);
    ser_tx_valid   <= 1'b1;
    ser_tx_unicast <= uni;
    ser_tx_dest    <= dst;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ser_tx_ready_q !== 1'b1 && n < lim);
    ok = (ser_tx_ready_q === 1'b1);
    ser_tx_valid   <= 1'b0;
    ser_tx_unicast <= ~uni;
    ser_tx_dest    <= ~dst;
  endtask
endmodule

// [dv/tb_sleep_mode_and_indirect_polling.sv]
// Testbench for the sleep controller and indirect queue
`timescale 1ns/10ps
module tb_sleep_mode_and_indirect_polling;
  reg clk_sys, reset_n, wb_we_i, wb_cyc_i, wb_stb_i, rf_data_rx, rf_poll_rx, rf_sync_rx;
  reg rf_join_req, net_awake, rf_busy;
  reg [7:0] wb_adr_i;
  reg [31:0] wb_dat_i, rf_sync_sleep, rf_sync_wake;
  reg [3:0] wb_sel_i;
  reg [63:0] rf_poll_src;
  wire [31:0] wb_dat_o;
  wire [63:0] rf_send_dest_q, ser_tx_dest;
  wire [7:0] tx_status_code_q;
  wire [1:0] rf_send_slot_q;
  wire wb_ack_o, ser_tx_ready_q, rf_send_q, rf_send_poll_q, rf_send_sync_q, rf_relay_sync_q;
  wire rf_rx_enable_q, tx_status_q, awake_q, cts_n_q, sleep_request_pin, serial_data_rx;
  wire ser_tx_valid, ser_tx_unicast, ser_fifo_full;
  int num_errors, compares, cycles;
  logic ok;
  slp_ctrl #(.MS_CYCLES(20)) uut (.*);
  slp_host_model host (.*);
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  task print_verdict;
    $display("compares=%0d num_errors=%0d", compares, num_errors);
    if (num_errors == 0 && compares > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cycles++;
    if (cycles == 40000) begin
      num_errors++;
      print_verdict();
    end
  end
  task chk(input logic [63:0] got, input logic [63:0] exp);
    compares++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wb_cycle(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] q);
    int n;
    @(posedge clk_sys);
    {wb_adr_i, wb_we_i, wb_dat_i, wb_cyc_i, wb_stb_i} <= {a, we, d, 2'b11};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    {wb_we_i, wb_cyc_i, wb_stb_i} <= 3'b000;
    chk(n < 50, 1'b1);
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb_cycle(a, 1'b1, d, q);
  endtask
  task rd_chk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] q;
    wb_cycle(a, 1'b0, 32'h0, q);
    chk(q, exp);
  endtask
  function logic pick(input int s);
    case (s)
      0: pick = awake_q;
      1: pick = rf_send_q;
      2: pick = rf_send_poll_q;
      3: pick = tx_status_q;
      4: pick = rf_send_sync_q;
      default: pick = cts_n_q;
    endcase
  endfunction
  task wait_on(input int s, input logic v, input int lim);
    int n;
    n = 0;
    while (pick(s) !== v && n < lim) begin
      @(posedge clk_sys);
      n++;
    end
    chk(pick(s), v);
  endtask
  task do_reset;
    reset_n <= 1'b0;
    repeat (5) @(posedge clk_sys);
    reset_n <= 1'b1;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    {reset_n, wb_we_i, wb_cyc_i, wb_stb_i, rf_data_rx, rf_poll_rx, rf_sync_rx} = 7'h00;
    {rf_join_req, rf_busy, net_awake, wb_adr_i, wb_sel_i} = {3'b001, 8'h00, 4'hf};
    {wb_dat_i, rf_sync_sleep, rf_sync_wake, rf_poll_src} = 160'h0;
    num_errors = 0;
    compares = 0;
    cycles = 0;
    do_reset();
    rd_chk(8'h00, 32'h0);
    rd_chk(8'h04, 32'h64);
    rd_chk(8'h08, 32'ha);
    rd_chk(8'h24, 32'h0);
    repeat (100) @(posedge clk_sys);
    chk(awake_q, 1'b1);
    $display("defaults done");
    do_reset();
    wr(8'h10, 32'h1234);
    wr(8'h00, 32'h261);
    rf_busy <= 1'b1;
    host.set_pin(1'b1);
    repeat (20) @(posedge clk_sys);
    chk(awake_q, 1'b1);
    rf_busy <= 1'b0;
    wait_on(0, 1'b0, 20);
    wait_on(5, 1'b1, 4);
    host.set_pin(1'b0);
    wait_on(0, 1'b1, 20);
    wait_on(2, 1'b1, 2100);
    wait_on(2, 1'b0, 2);
    wait_on(2, 1'b1, 2100);
    $display("pin sleep done");
    do_reset();
    wr(8'h04, 32'h2);
    wr(8'h08, 32'h3);
    wr(8'h00, 32'h4);
    wait_on(0, 1'b0, 100);
    wait_on(0, 1'b1, 60);
    fork
      repeat (70) host.data_pulse();
      begin
        @(posedge clk_sys);
        repeat (70) begin
          @(posedge clk_sys);
          rf_data_rx <= 1'b1;
          @(posedge clk_sys);
          rf_data_rx <= 1'b0;
        end
      end
    join
    repeat (40) @(posedge clk_sys);
    chk(awake_q, 1'b1);
    wait_on(0, 1'b0, 40);
    wr(8'h00, 32'h5);
    wait_on(0, 1'b1, 8);
    host.set_pin(1'b1);
    wait_on(0, 1'b0, 200);
    host.set_pin(1'b0);
    wait_on(0, 1'b1, 8);
    $display("cyclic done");
    do_reset();
    wr(8'h04, 32'h10);
    wr(8'h00, 32'h150);
    host.send(1'b0, 64'hffff, 20, ok);
    wait_on(1, 1'b1, 4);
    host.send(1'b1, 64'haa, 20, ok);
    @(posedge clk_sys);
    {rf_poll_rx, rf_poll_src} <= {1'b1, 64'haa};
    @(posedge clk_sys);
    {rf_poll_rx, rf_poll_src} <= {1'b0, ~64'haa};
    wait_on(1, 1'b1, 4);
    chk(rf_send_dest_q, 64'haa);
    repeat (4) host.send(1'b1, 64'hbb, 20, ok);
    host.send(1'b1, 64'hbb, 20, ok);
    chk(ok, 1'b0);
    host.set_full(1'b1);
    wait_on(5, 1'b1, 4);
    host.set_full(1'b0);
    wait_on(3, 1'b1, 1000);
    chk(tx_status_code_q, 8'h75);
    host.send(1'b1, 64'hcc, 20, ok);
    chk(ok, 1'b1);
    $display("queue done");
    do_reset();
    wb_sel_i <= 4'h1;
    wr(8'h00, 32'h307);
    wb_sel_i <= 4'hf;
    rd_chk(8'h00, 32'h7);
    @(posedge clk_sys);
    rf_join_req <= 1'b1;
    @(posedge clk_sys);
    rf_join_req <= 1'b0;
    wait_on(4, 1'b1, 6);
    net_awake <= 1'b0;
    host.send(1'b0, 64'h77, 20, ok);
    @(posedge clk_sys);
    chk(rf_send_q, 1'b0);
    net_awake <= 1'b1;
    wr(8'h00, 32'hc8);
    @(posedge clk_sys);
    {rf_sync_rx, rf_sync_sleep, rf_sync_wake} <= {1'b1, 32'h3, 32'h2};
    @(posedge clk_sys);
    {rf_sync_rx, rf_sync_sleep, rf_sync_wake} <= {1'b0, ~32'h3, ~32'h2};
    rd_chk(8'h18, 32'h3);
    rd_chk(8'h1c, 32'h2);
    wait_on(0, 1'b0, 200);
    chk(cts_n_q, 1'b1);
    wait_on(0, 1'b1, 200);
    $display("sync done");
    print_verdict();
  end
endmodule
